// ==== inc/debug_bridge_regs.svh ====
`ifndef DEBUG_BRIDGE_REGS_SVH
`define DEBUG_BRIDGE_REGS_SVH

// Register byte offsets on the APB slave.
`define FEC_OFFSET 12'h000
`define CODING_OFFSET 12'h004
`define STATUS_OFFSET 12'h008

// Feature-enable control fields.
`define FEC_EXT_OFF_BIT 2
`define FEC_REDUCED_CLK_BIT 1
`define FEC_FUSE_GUARD_BIT 0
`define FEC_IMPL_RESET 3'h7
`define FEC_RSVD_VALUE 5'h1f

// Line coding fields.
`define CODING_BAUD_LSB 0
`define CODING_BAUD_MSB 15
`define CODING_PARITY_LSB 16
`define CODING_PARITY_MSB 17
`define CODING_STOP_BIT 18
`define CODING_RESET 19'h00068

// Status fields.
`define STAT_SLEEP_BIT 0
`define STAT_REDUCED_BIT 1
`define STAT_ENUM_BIT 2
`define STAT_DTR_BIT 3
`define STAT_HIGH_V_BIT 4
`define STAT_BOOT_BIT 5

// Clocking and timing.
`define SYS_CLK_MHZ 200
`define OUT_CLK_LOW_V_MHZ 8
`define OUT_CLK_HIGH_V_MHZ 16
`define OUT_CLK_REDUCED_MHZ 1
`define ENUM_TIMEOUT_MS 5000
`define LED_BOOT_MS 100
`define LED_FLASH_HALF_MS 50
`define ENUM_TIMEOUT_CYC (`ENUM_TIMEOUT_MS * 1000 * `SYS_CLK_MHZ)
`define LED_BOOT_CYC (`LED_BOOT_MS * 1000 * `SYS_CLK_MHZ)
`define LED_FLASH_HALF_CYC (`LED_FLASH_HALF_MS * 1000 * `SYS_CLK_MHZ)

`endif

// ==== inc/debug_bridge_pkg.sv ====
package debug_bridge_pkg;

    typedef enum logic [2:0] {
        ST_BOOT = 3'b001,
        ST_RUN = 3'b010,
        ST_SLEEP = 3'b100
    } bridge_state_t;

    typedef logic [4:0] clk_mhz_t;

endpackage : debug_bridge_pkg

// ==== inc/clk_ctrl_if.sv ====
`timescale 1ns/10ps
interface clk_ctrl_if;
    import debug_bridge_pkg::*;
    logic enable;
    clk_mhz_t freq_mhz;
    modport ctrl (output enable, output freq_mhz);
    modport gen (input enable, input freq_mhz);
endinterface : clk_ctrl_if

// ==== hdl/bridge_clk_synth.sv ====
`timescale 1ns/10ps
`include "debug_bridge_regs.svh"
module bridge_clk_synth
    import debug_bridge_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    clk_ctrl_if.gen ctrl,
    output logic clk_out_o
);
    // Phase accumulator toggles the output 2*f times per 200 cycles, so the
    // mean rate is exact; 8 and 16 MHz carry up to one cycle of edge jitter.
    localparam logic [8:0] MOD = 9'(`SYS_CLK_MHZ);

    logic [8:0] acc_r;
    logic [8:0] acc_nxt;
    logic clk_r;
    logic clk_nxt;
    logic [8:0] sum;

    always_comb begin
        sum = acc_r + {3'h0, ctrl.freq_mhz, 1'b0};
        acc_nxt = acc_r;
        clk_nxt = clk_r;
        if (!ctrl.enable) begin
            acc_nxt = 9'h000;
            clk_nxt = 1'b0;
        end else if (sum >= MOD) begin
            acc_nxt = sum - MOD;
            clk_nxt = ~clk_r;
        end else begin
            acc_nxt = sum;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_r <= 9'h000;
            clk_r <= 1'b0;
        end else begin
            acc_r <= acc_nxt;
            clk_r <= clk_nxt;
        end
    end

    assign clk_out_o = clk_r;

endmodule : bridge_clk_synth

// ==== hdl/debug_bridge_power_config.sv ====
// Notes on behaviour
// R01 - UART pins toward the target stay undriven until the host raises DTR.
// R02 - One composite USB device carries a debugger and a serial function.
// R03 - Baud, parity and stop bits are selectable and the target must match.
// R04 - The LED is lit at boot, dark in use and flashing while programming.
// R05 - Clock output is 8 MHz for a 3.3 V target and 16 MHz for 5.0 V.
// R06 - With extended-off at 0, no USB enumeration within 5 s leads to sleep.
// R07 - Sleep disables the clock output, serial port, programming and debug.
// R08 - Reduced-clock bit 0 gives 1 MHz system clock and 1 the default clock.
// R09 - Reduced clock: 1 MHz output, serial on, programming and debug off.
// R10 - Fuse guard at 1 refuses critical fuse writes; at 0 all are allowed (here every fuse write is refused while link_en_r is low).
// R11 - After reset everything is enabled with no configuration write needed.
// R12 - Upper feature-enable bits read as one and ignore writes.
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
`include "debug_bridge_regs.svh"
module debug_bridge_power_config
    import debug_bridge_pkg::*;
#(
    parameter int unsigned ENUM_TIMEOUT_CYC = `ENUM_TIMEOUT_CYC,
    parameter int unsigned LED_BOOT_CYC = `LED_BOOT_CYC,
    parameter int unsigned LED_FLASH_HALF_CYC = `LED_FLASH_HALF_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic usb_enumerated_i,
    input wire logic dtr_i,
    input wire logic target_high_v_i,
    input wire logic prog_active_i,
    input wire logic fuse_wr_req_i,
    input wire logic fuse_critical_i,
    input wire logic uart_txd_i,
    input wire logic uart_rxd_i,
    output logic uart_txd_o,
    output logic uart_txd_oe_o,
    output logic uart_rxd_o,
    output logic [15:0] baud_div_o,
    output logic [1:0] parity_o,
    output logic stop2_o,
    output logic usb_debug_func_en_o,
    output logic usb_serial_func_en_o,
    output logic single_wire_prog_link_en_o,
    output logic debug_en_o,
    output logic sysclk_reduced_o,
    output logic fuse_wr_accept_o,
    output logic fuse_wr_refuse_o,
    output logic status_led_o,
    output logic clk_out_o
);

    // Bus slave state.
    logic pready_r;
    logic pready_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic [2:0] fec_r;
    logic [2:0] fec_nxt;
    logic [18:0] coding_r;
    logic [18:0] coding_nxt;

    // Mode state.
    bridge_state_t state_r;
    bridge_state_t state_nxt;
    logic [31:0] boot_cnt_r;
    logic [31:0] boot_cnt_nxt;
    logic [31:0] tmo_cnt_r;
    logic [31:0] tmo_cnt_nxt;
    logic enum_seen_r;
    logic enum_seen_nxt;
    logic [31:0] flash_cnt_r;
    logic [31:0] flash_cnt_nxt;
    logic led_r;
    logic led_nxt;

    // Pin and function state.
    logic txd_r;
    logic txd_nxt;
    logic txd_oe_r;
    logic txd_oe_nxt;
    logic rxd_r;
    logic rxd_nxt;
    logic link_en_r;
    logic link_en_nxt;
    logic serial_en_r;
    logic serial_en_nxt;
    logic debug_func_r;
    logic debug_func_nxt;
    logic reduced_r;
    logic reduced_nxt;
    logic accept_r;
    logic accept_nxt;
    logic refuse_r;
    logic refuse_nxt;

    logic [31:0] fec_word;
    logic [31:0] status_word;
    logic sleeping;

    clk_ctrl_if clk_ctrl ();

    assign fec_word = {24'h000000, `FEC_RSVD_VALUE, fec_r}; // R12
    assign sleeping = (state_r == ST_SLEEP);

    always_comb begin
        status_word = 32'h00000000;
        status_word[`STAT_SLEEP_BIT] = sleeping;
        status_word[`STAT_REDUCED_BIT] = ~fec_r[`FEC_REDUCED_CLK_BIT];
        status_word[`STAT_ENUM_BIT] = enum_seen_r;
        status_word[`STAT_DTR_BIT] = dtr_i;
        status_word[`STAT_HIGH_V_BIT] = target_high_v_i;
        status_word[`STAT_BOOT_BIT] = (state_r == ST_BOOT);
    end

    // APB slave: answer decoded in the setup cycle, pready high in the
    // first access cycle, so every transfer has zero wait states.
    always_comb begin
        pready_nxt = psel_i & ~penable_i;
        pslverr_nxt = 1'b0;
        prdata_nxt = prdata_r;
        fec_nxt = fec_r;
        coding_nxt = coding_r;
        if (psel_i && !penable_i) begin
            prdata_nxt = 32'h00000000;
            case (paddr_i)
                `FEC_OFFSET: begin
                    prdata_nxt = fec_word;
                end
                `CODING_OFFSET: begin
                    prdata_nxt = {13'h0000, coding_r};
                end
                `STATUS_OFFSET: begin
                    prdata_nxt = status_word;
                    pslverr_nxt = pwrite_i;
                end
                default: begin
                    pslverr_nxt = 1'b1;
                end
            endcase
        end
        if (psel_i && penable_i && pready_r && pwrite_i && !pslverr_r) begin
            case (paddr_i)
                `FEC_OFFSET: begin
                    if (pstrb_i[0]) begin
                        fec_nxt = pwdata_i[2:0]; // R12
                    end
                end
                `CODING_OFFSET: begin
                    if (pstrb_i[0]) begin
                        coding_nxt[7:0] = pwdata_i[7:0]; // R03
                    end
                    if (pstrb_i[1]) begin
                        coding_nxt[15:8] = pwdata_i[15:8];
                    end
                    if (pstrb_i[2]) begin
                        coding_nxt[18:16] = pwdata_i[18:16];
                    end
                end
                default: begin
                    fec_nxt = fec_r;
                end
            endcase
        end
    end

    // Power-up, run and deep-sleep sequencing.
    always_comb begin
        state_nxt = state_r;
        boot_cnt_nxt = boot_cnt_r;
        tmo_cnt_nxt = tmo_cnt_r;
        enum_seen_nxt = enum_seen_r | usb_enumerated_i;
        flash_cnt_nxt = 32'h00000000;
        led_nxt = 1'b0;
        if (!enum_seen_r && tmo_cnt_r < ENUM_TIMEOUT_CYC) begin
            tmo_cnt_nxt = tmo_cnt_r + 32'h00000001;
        end
        case (state_r)
            ST_BOOT: begin
                led_nxt = 1'b1; // R04
                boot_cnt_nxt = boot_cnt_r + 32'h00000001;
                if (boot_cnt_r >= LED_BOOT_CYC - 32'h00000001) begin
                    state_nxt = ST_RUN;
                    led_nxt = 1'b0;
                end
            end
            ST_RUN: begin
                if (prog_active_i && link_en_r) begin
                    led_nxt = led_r; // R04
                    flash_cnt_nxt = flash_cnt_r + 32'h00000001;
                    if (flash_cnt_r >= LED_FLASH_HALF_CYC - 32'h00000001) begin
                        flash_cnt_nxt = 32'h00000000;
                        led_nxt = ~led_r;
                    end
                end
            end
            ST_SLEEP: begin
                led_nxt = 1'b0;
            end
            default: begin
                state_nxt = ST_SLEEP;
            end
        endcase
        // Only a reset leaves deep sleep.
        if (!fec_r[`FEC_EXT_OFF_BIT] && !enum_seen_r
            && tmo_cnt_r >= ENUM_TIMEOUT_CYC) begin
            state_nxt = ST_SLEEP; // R06
            led_nxt = 1'b0;
        end
    end

    // Function enables, UART pins and the fuse filter.
    always_comb begin
        serial_en_nxt = ~sleeping; // R07
        debug_func_nxt = ~sleeping; // R02
        link_en_nxt = ~sleeping & fec_r[`FEC_REDUCED_CLK_BIT]; // R09
        reduced_nxt = ~fec_r[`FEC_REDUCED_CLK_BIT]; // R08
        txd_oe_nxt = dtr_i & ~sleeping; // R01
        txd_nxt = txd_oe_nxt ? uart_txd_i : 1'b1;
        rxd_nxt = txd_oe_nxt ? uart_rxd_i : 1'b1;
        accept_nxt = 1'b0;
        refuse_nxt = 1'b0;
        if (fuse_wr_req_i) begin
            if (!link_en_r) begin
                refuse_nxt = 1'b1;
            end else if (fec_r[`FEC_FUSE_GUARD_BIT] && fuse_critical_i) begin
                refuse_nxt = 1'b1; // R10
            end else begin
                accept_nxt = 1'b1;
            end
        end
    end

    // Clock output request for the synthesiser.
    always_comb begin
        clk_ctrl.enable = ~sleeping; // R07
        if (!fec_r[`FEC_REDUCED_CLK_BIT]) begin
            clk_ctrl.freq_mhz = 5'(`OUT_CLK_REDUCED_MHZ); // R09
        end else if (target_high_v_i) begin
            clk_ctrl.freq_mhz = 5'(`OUT_CLK_HIGH_V_MHZ); // R05
        end else begin
            clk_ctrl.freq_mhz = 5'(`OUT_CLK_LOW_V_MHZ); // R05
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
            fec_r <= `FEC_IMPL_RESET; // R11
            coding_r <= `CODING_RESET;
            state_r <= ST_BOOT;
            boot_cnt_r <= 32'h00000000;
            tmo_cnt_r <= 32'h00000000;
            enum_seen_r <= 1'b0;
            flash_cnt_r <= 32'h00000000;
            led_r <= 1'b1;
            txd_r <= 1'b1;
            txd_oe_r <= 1'b0;
            rxd_r <= 1'b1;
            link_en_r <= 1'b1;
            serial_en_r <= 1'b1;
            debug_func_r <= 1'b1;
            reduced_r <= 1'b0;
            accept_r <= 1'b0;
            refuse_r <= 1'b0;
        end else begin
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r <= prdata_nxt;
            fec_r <= fec_nxt;
            coding_r <= coding_nxt;
            state_r <= state_nxt;
            boot_cnt_r <= boot_cnt_nxt;
            tmo_cnt_r <= tmo_cnt_nxt;
            enum_seen_r <= enum_seen_nxt;
            flash_cnt_r <= flash_cnt_nxt;
            led_r <= led_nxt;
            txd_r <= txd_nxt;
            txd_oe_r <= txd_oe_nxt;
            rxd_r <= rxd_nxt;
            link_en_r <= link_en_nxt;
            serial_en_r <= serial_en_nxt;
            debug_func_r <= debug_func_nxt;
            reduced_r <= reduced_nxt;
            accept_r <= accept_nxt;
            refuse_r <= refuse_nxt;
        end
    end

    bridge_clk_synth u_clk_synth (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ctrl(clk_ctrl.gen),
        .clk_out_o(clk_out_o)
    );

    assign prdata_o = prdata_r;
    assign pready_o = pready_r;
    assign pslverr_o = pslverr_r;
    assign uart_txd_o = txd_r;
    assign uart_txd_oe_o = txd_oe_r;
    assign uart_rxd_o = rxd_r;
    assign baud_div_o = coding_r[`CODING_BAUD_MSB:`CODING_BAUD_LSB];
    assign parity_o = coding_r[`CODING_PARITY_MSB:`CODING_PARITY_LSB];
    assign stop2_o = coding_r[`CODING_STOP_BIT];
    assign usb_debug_func_en_o = debug_func_r;
    assign usb_serial_func_en_o = serial_en_r;
    assign single_wire_prog_link_en_o = link_en_r;
    assign debug_en_o = link_en_r;
    assign sysclk_reduced_o = reduced_r;
    assign fuse_wr_accept_o = accept_r;
    assign fuse_wr_refuse_o = refuse_r;
    assign status_led_o = led_r;

endmodule : debug_bridge_power_config

// ==== tb/bridge_assertions.sv ====
`timescale 1ns/10ps
module bridge_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic dtr_i,
    input wire logic fuse_wr_req_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic uart_txd_oe_o,
    input wire logic fuse_wr_accept_o,
    input wire logic fuse_wr_refuse_o,
    input wire logic sysclk_reduced_o,
    input wire logic single_wire_prog_link_en_o,
    input wire logic debug_en_o,
    input wire logic usb_serial_func_en_o,
    input wire logic clk_out_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ready_after_setup:
    assert property (psel_i && !penable_i |=> pready_o)
        else $error("ready missing after setup");
    a_ready_single:
    assert property (pready_o |=> !pready_o)
        else $error("ready held too long");
    a_err_with_ready:
    assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    a_oe_needs_dtr:
    assert property (uart_txd_oe_o |-> $past(dtr_i))
        else $error("uart driven without dtr");
    a_fuse_one_answer:
    assert property (fuse_wr_req_i |=> fuse_wr_accept_o ^ fuse_wr_refuse_o)
        else $error("fuse request not answered once");
    a_fuse_no_spurious:
    assert property (!fuse_wr_req_i
        |=> !(fuse_wr_accept_o || fuse_wr_refuse_o))
        else $error("fuse answer without request");
    a_reduced_no_link:
    assert property (sysclk_reduced_o |-> !single_wire_prog_link_en_o
        && !debug_en_o) else $error("link usable at reduced clock");
    a_reduced_serial_on:
    assert property ($rose(sysclk_reduced_o) |-> usb_serial_func_en_o)
        else $error("serial lost at reduced clock");
    a_sleep_quiet:
    assert property (!usb_serial_func_en_o |-> ##2 (!clk_out_o
        && !single_wire_prog_link_en_o && !debug_en_o))
        else $error("outputs active in sleep");
    c_refuse: cover property (fuse_wr_refuse_o);
    c_sleep: cover property ($fell(usb_serial_func_en_o));
    c_reduced: cover property ($rose(sysclk_reduced_o));
endmodule : bridge_checker

bind debug_bridge_power_config bridge_checker chk (
    .clk_i, .rst_i, .psel_i, .penable_i, .dtr_i, .fuse_wr_req_i,
    .pready_o, .pslverr_o, .uart_txd_oe_o, .fuse_wr_accept_o,
    .fuse_wr_refuse_o, .sysclk_reduced_o, .single_wire_prog_link_en_o,
    .debug_en_o, .usb_serial_func_en_o, .clk_out_o
);

// ==== tb/uart_partner.sv ====
`timescale 1ns/10ps
module uart_partner (
    input wire logic clk_i,
    input wire logic open_i,
    input wire logic txd_i,
    input wire logic txd_oe_i,
    output logic dtr_o,
    output logic line_o,
    output logic rxd_o
);
    logic last_r = 1'b1;
    logic pat_r = 1'b0;
    assign dtr_o = open_i;
    // A released line shows the inverse of its last driven level.
    assign line_o = txd_oe_i ? txd_i : ~last_r;
    assign rxd_o = pat_r;
    always @(posedge clk_i) begin
        if (txd_oe_i) last_r <= txd_i;
        pat_r <= ~pat_r;
    end
endmodule : uart_partner

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
module testbench;
    logic clk_i = 1'b0, rst_i = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, enumd = 1'b1, high_v = 1'b1, prog = 1'b0;
    logic freq = 1'b0, fcrit = 1'b0, txd = 1'b1, open = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, txd_o, txd_oe, dbg_f, ser_f, link, dbg;
    logic red, acc, rfs, led, cko, dtr, line, rxd, stop2;
    logic rxo, rxd_d = 1'b1;
    logic [15:0] baud;
    logic [1:0] par;
    int n_errors = 0, tests_run = 0, cyc = 0;
    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) rxd_d <= rxd;
    uart_partner peer (.clk_i(clk_i), .open_i(open), .txd_i(txd_o),
        .txd_oe_i(txd_oe), .dtr_o(dtr), .line_o(line), .rxd_o(rxd));
    debug_bridge_power_config #(.ENUM_TIMEOUT_CYC(200), .LED_BOOT_CYC(20),
        .LED_FLASH_HALF_CYC(5)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .usb_enumerated_i(enumd), .dtr_i(dtr), .target_high_v_i(high_v),
        .prog_active_i(prog), .fuse_wr_req_i(freq),
        .fuse_critical_i(fcrit), .uart_txd_i(txd), .uart_rxd_i(rxd),
        .uart_txd_o(txd_o), .uart_txd_oe_o(txd_oe), .uart_rxd_o(rxo),
        .baud_div_o(baud), .parity_o(par), .stop2_o(stop2),
        .usb_debug_func_en_o(dbg_f), .usb_serial_func_en_o(ser_f),
        .single_wire_prog_link_en_o(link), .debug_en_o(dbg),
        .sysclk_reduced_o(red), .fuse_wr_accept_o(acc),
        .fuse_wr_refuse_o(rfs), .status_led_o(led), .clk_out_o(cko));
    function logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr
    function logic near(input int e, input int x);
        return e >= x - 1 && e <= x + 1;
    endfunction : near
    function logic [31:0] fec_exp(input logic [31:0] v);
        return {24'h0, 5'h1f, v[2:0]};
    endfunction : fec_exp
    task check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic er);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do @(posedge clk_i); while (pready !== 1'b1);
        r = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_i);
    endtask : apb
    // Counts rising edges of the clock output, or of the LED when sel.
    task edges(input logic sel, input int n, output int e);
        logic p;
        e = 0;
        p = sel ? led : cko;
        repeat (n) begin
            @(posedge clk_i);
            if ((sel ? led : cko) && !p) e++;
            p = sel ? led : cko;
        end
    endtask : edges
    task final_report;
        $display("tests %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 6000) begin
            n_errors++;
            final_report();
        end
    end
    initial begin
        int e;
        logic [31:0] r, v;
        logic er;
        logic [15:0] s;
        s = 16'hb592;
        tick(8);
        rst_i <= 1'b0;
        tick(2);
        check(led, 1);
        tick(25);
        check(led, 0);
        check({dbg_f, ser_f, link, dbg, red}, 5'b11110);
        check({stop2, par, baud}, 19'h00068);
        apb(0, 12'h000, 0, r, er);
        check(r, 32'hff);
        edges(0, 400, e);
        check(near(e, 32), 1);
        high_v <= 1'b0;
        tick(5);
        edges(0, 400, e);
        check(near(e, 16), 1);
        $display("test reset_clock done");
        check(txd_oe, 0);
        check(rxo, 1);
        open <= 1'b1;
        tick(3);
        check(txd_oe, 1);
        repeat (4) begin
            s = lfsr(s);
            txd <= s[0];
            tick(2);
            check(line, s[0]);
            check(rxo, rxd_d);
        end
        repeat (3) begin
            s = lfsr(s);
            v = {13'h0, s[2:0], s};
            apb(1, 12'h004, v, r, er);
            check({stop2, par, baud}, v);
        end
        $display("test serial done");
        for (int g = 0; g < 2; g++) begin
            for (int c = 0; c < 2; c++) begin
                apb(1, 12'h000, 32'h6 | g, r, er);
                freq <= 1'b1;
                fcrit <= c[0];
                @(posedge clk_i);
                freq <= 1'b0;
                @(posedge clk_i);
                check({acc, rfs}, (g && c) ? 2'b01 : 2'b10);
            end
        end
        repeat (4) begin
            s = lfsr(s);
            apb(1, 12'h000, {s, s}, r, er);
            apb(0, 12'h000, 0, r, er);
            check(r, fec_exp({s, s}));
            check(red, !s[1]);
        end
        apb(1, 12'h000, 32'hfd, r, er);
        tick(3);
        check({red, link, dbg, ser_f}, 4'b1001);
        edges(0, 420, e);
        check(near(e, 2), 1);
        apb(1, 12'h000, 32'hff, r, er);
        tick(3);
        prog <= 1'b1;
        edges(1, 40, e);
        check(near(e, 4), 1);
        prog <= 1'b0;
        tick(3);
        check(led, 0);
        apb(0, 12'h00c, 0, r, er);
        check({er, r[7:0]}, 9'h100);
        apb(1, 12'h008, 32'h0, r, er);
        check(er, 1);
        $display("test config done");
        enumd <= 1'b0;
        rst_i <= 1'b1;
        tick(8);
        rst_i <= 1'b0;
        tick(1);
        apb(1, 12'h000, 32'hfb, r, er);
        check(ser_f, 1);
        tick(220);
        check({ser_f, dbg_f, link, dbg, txd_oe, cko}, 6'h0);
        check(rxo, 1);
        apb(0, 12'h008, 0, r, er);
        check(r, 32'h9);
        $display("test sleep done");
        final_report();
    end
endmodule : testbench
